// [core/rtie_defs.svh]
`ifndef RTIE_DEFS_SVH
`define RTIE_DEFS_SVH
// register indices; the byte address on the bus is four times the index
`define RTIE_IDX_SYSCTL 16'hFFF2
`define RTIE_IDX_SENSE 16'hFFF4
`define RTIE_IDX_PINEN 16'hFFF5
`define RTIE_IDX_FLAGS 16'hFFF6
`define RTIE_IDX_PRIA 16'hFFF8
`define RTIE_IDX_PRIB 16'hFFF9
// reset values
`define RTIE_RST_SYSCTL 8'h0B
`define RTIE_RST_REG8 8'h00
// field positions
`define RTIE_BIT_USER_EN 3
`define RTIE_BIT_NMI_EDGE 2
`define RTIE_BIT_COND_MASK 7
`define RTIE_BIT_COND_USER 6
// vector numbers; sources after the nmi take their index plus this offset
`define RTIE_VEC_NMI 6'h07
`define RTIE_VEC_TRAP 6'h08
`define RTIE_VEC_SRC_OFS 6'h0B
// reset vector sits at byte address zero and is four bytes long
`define RTIE_VADDR_RESET 8'h00
`define RTIE_VEC_LAST_BYTE 2'h3
// stack frame of pc and condition codes, in bytes
`define RTIE_FRAME_BYTES 16'h0004
// cycles the core stays in reset after a watchdog overflow
`define RTIE_WDT_HOLD 10
`endif

// [core/rtie_pkg.sv]
package rtie_pkg;
  typedef enum logic [2:0] {
    ST_RESET = 3'h0,
    ST_INIT = 3'h1,
    ST_FETCH = 3'h2,
    ST_FIRST = 3'h3,
    ST_RUN = 3'h4,
    ST_PUSH = 3'h5
  } rtie_state_type;
endpackage

// [core/rtie_arb_if.sv]
`timescale 1ns/1ps
interface rtie_arb_if #(parameter int N = 43);
  logic [N-1:0] req;
  logic [N-1:0] hi;
  logic allow_lo;
  logic allow_hi;
  logic valid;
  logic [5:0] idx;
  modport arb(input req, input hi, input allow_lo, input allow_hi, output valid, output idx);
  modport host(output req, output hi, output allow_lo, output allow_hi, input valid, input idx);
endinterface

// [core/rtie_pin_sense.sv]
`timescale 1ns/1ps
module rtie_pin_sense (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic pin_i,
  input wire logic rise_i,
  input wire logic level_i,
  input wire logic clr_i,
  output logic flag_o
);
  logic prev_q;
  logic flag_q;
  wire fall_hit = ~pin_i & prev_q;
  wire rise_hit = pin_i & ~prev_q;
  wire edge_hit = rise_i ? rise_hit : fall_hit;
  wire hit = level_i ? ~pin_i : edge_hit;

  // the previous level is loaded from the pin in reset so no false edge follows release
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prev_q <= pin_i;
      flag_q <= 1'b0;
    end else begin
      prev_q <= pin_i;
      flag_q <= hit | (flag_q & ~clr_i); // a new hit beats a clear in the same cycle
    end
  end

  assign flag_o = flag_q;
endmodule

// [core/rtie_arbiter.sv]
`timescale 1ns/1ps
module rtie_arbiter #(parameter int N = 43) (
  rtie_arb_if.arb a
);
  logic hi_valid;
  logic lo_valid;
  logic [5:0] hi_idx;
  logic [5:0] lo_idx;

  // scan downward so the lowest index wins inside each level
  always_comb begin
    hi_valid = 1'b0;
    lo_valid = 1'b0;
    hi_idx = 6'h00;
    lo_idx = 6'h00;
    for (int k = N - 1; k >= 1; k--) begin
      if (a.req[k] && a.hi[k]) begin
        hi_valid = 1'b1;
        hi_idx = 6'(k);
      end
      if (a.req[k] && !a.hi[k]) begin
        lo_valid = 1'b1;
        lo_idx = 6'(k);
      end
    end
  end

  wire take_hi = a.allow_hi & hi_valid;
  wire take_lo = a.allow_lo & lo_valid;
  // source zero is the nmi: never masked, always first
  assign a.valid = a.req[0] | take_hi | take_lo;
  assign a.idx = a.req[0] ? 6'h00 : (take_hi ? hi_idx : lo_idx);
endmodule

// [core/rtie_top.sv]
// The Wishbone interface to the registers was left to the implementer.
`timescale 1ns/1ps
`include "rtie_defs.svh"
// Summary of operation
// - reset pin low halts everything, overrides all
// - reset handling starts on pin release
// - watchdog overflow also resets the device
// - reset initializes state, sets mask bit
// - fetch reset vector bytes 0 to 3
// - all interrupts blocked right after reset
// - first instruction runs without interruption
// - nine external, 34 internal, distinct vectors
// - nmi highest and always accepted
// - two priority levels, simultaneous requests arbitrated
// - three mask levels from mask bits
// - nmi edge polarity selectable
// - request pins falling edge or low level
// - trap sets mask, user bit per option
// - trap vector number 0 to 3
// - wide accesses force address bit zero low
// - flags clear by writing 0 only
// - entry pushes pc and codes, masks, vectors
// - user bit enable selects user bit role
// - nmi select 0 falling, 1 rising
module rtie_top #(
  parameter int NUM_IRQ = 8,
  parameter int NUM_INT = 34,
  parameter int WDT_HOLD = `RTIE_WDT_HOLD
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic reset_pin_n_i,
  input wire logic wdt_overflow_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [17:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic nmi_i,
  input wire logic [NUM_IRQ-1:0] irq_pin_n_i,
  input wire logic [NUM_INT-1:0] int_req_i,
  input wire logic [7:0] cond_code_reg_i,
  input wire logic [15:0] stack_pointer_i,
  input wire logic first_done_i,
  input wire logic trap_req_i,
  input wire logic [1:0] trap_num_i,
  input wire logic vec_ack_i,
  input wire logic [7:0] vec_data_i,
  input wire logic push_ack_i,
  input wire logic [15:0] mem_addr_i,
  input wire logic mem_wide_i,
  output logic cpu_halt_o,
  output logic periph_reset_o,
  output logic set_imask_o,
  output logic set_uimask_o,
  output logic vec_rd_o,
  output logic [15:0] vec_addr_o,
  output logic jump_o,
  output logic [31:0] jump_addr_o,
  output logic push_req_o,
  output logic [15:0] push_addr_o,
  output logic int_ack_o,
  output logic [5:0] int_vector_o,
  output logic trap_ack_o,
  output logic [15:0] mem_addr_o
);
  localparam int NSRC = 1 + NUM_IRQ + NUM_INT;

  rtie_pkg::rtie_state_type state_q;
  rtie_pkg::rtie_state_type state_d;
  logic [3:0] wdt_cnt_q;
  logic [7:0] sysctl_q;
  logic [7:0] sense_q;
  logic [7:0] pinen_q;
  logic [7:0] pria_q;
  logic [7:0] prib_q;
  logic wb_ack_q;
  logic [31:0] wb_dat_q;
  logic boot_q;
  logic [1:0] byte_q;
  logic [7:0] vaddr_q;
  logic [31:0] jaddr_q;
  logic jump_q;
  logic set_imask_q;
  logic set_uimask_q;
  logic int_ack_q;
  logic [5:0] int_vec_q;
  logic trap_ack_q;
  logic [15:0] push_addr_q;
  logic [15:0] mem_addr_q;
  logic nmi_flag;
  logic [NUM_IRQ-1:0] irq_flag;

  // any reset source; the pin and the watchdog hold share one path
  wire wdt_hold = wdt_cnt_q != 4'h0;
  wire in_rst = rst_i | ~reset_pin_n_i | wdt_overflow_i | wdt_hold;

  // watchdog hold counter is cleared only by the system reset so that it can run out
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wdt_cnt_q <= 4'h0;
    end else if (wdt_overflow_i) begin
      wdt_cnt_q <= 4'(WDT_HOLD);
    end else if (wdt_hold) begin
      wdt_cnt_q <= wdt_cnt_q - 4'h1;
    end
  end

  // bus decode
  wire [15:0] wb_idx = wb_adr_i[17:2];
  wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_q & ~in_rst;
  wire wb_wr = wb_req & wb_we_i & wb_sel_i[0];
  wire hit_sys = wb_idx == `RTIE_IDX_SYSCTL;
  wire hit_sense = wb_idx == `RTIE_IDX_SENSE;
  wire hit_pinen = wb_idx == `RTIE_IDX_PINEN;
  wire hit_flags = wb_idx == `RTIE_IDX_FLAGS;
  wire hit_pria = wb_idx == `RTIE_IDX_PRIA;
  wire hit_prib = wb_idx == `RTIE_IDX_PRIB;
  wire [7:0] wr_byte = wb_dat_i[7:0];

  // read mux; unmapped words read as zero
  wire [7:0] rd_byte = hit_sys ? sysctl_q :
                       hit_sense ? sense_q :
                       hit_pinen ? pinen_q :
                       hit_flags ? 8'(irq_flag) :
                       hit_pria ? pria_q :
                       hit_prib ? prib_q : 8'h00;

  // one wait state per access, ack registered the cycle after the strobe and dropped the cycle after
  always_ff @(posedge clk_i) begin
    if (in_rst) begin
      wb_ack_q <= 1'b0;
      wb_dat_q <= 32'h00000000;
    end else begin
      wb_ack_q <= wb_req;
      wb_dat_q <= wb_req ? {24'h000000, rd_byte} : wb_dat_q;
    end
  end

  // writable registers, all back to their reset values on any reset
  always_ff @(posedge clk_i) begin
    if (in_rst) begin
      sysctl_q <= `RTIE_RST_SYSCTL;
      sense_q <= `RTIE_RST_REG8;
      pinen_q <= `RTIE_RST_REG8;
      pria_q <= `RTIE_RST_REG8;
      prib_q <= `RTIE_RST_REG8;
    end else if (wb_wr) begin
      if (hit_sys) sysctl_q <= wr_byte;
      if (hit_sense) sense_q <= wr_byte;
      if (hit_pinen) pinen_q <= wr_byte;
      if (hit_pria) pria_q <= wr_byte;
      if (hit_prib) prib_q <= wr_byte;
    end
  end

  // mask view of the condition codes and the system control options;
  // with the user bit enable set, the second condition code bit is free for software
  wire user_bit_enable = sysctl_q[`RTIE_BIT_USER_EN];
  wire nmi_rise = sysctl_q[`RTIE_BIT_NMI_EDGE];
  wire cond_mask = cond_code_reg_i[`RTIE_BIT_COND_MASK];
  wire user_or_mask_bit = cond_code_reg_i[`RTIE_BIT_COND_USER];

  rtie_arb_if #(.N(NSRC)) arb ();

  // the nmi pending flag clears on its own acceptance, pin flags only by software
  // flags clear where a zero is written, a one leaves them alone
  wire flag_wr = wb_wr & hit_flags;
  wire nmi_clr = int_ack_q & (int_vec_q == `RTIE_VEC_NMI);

  rtie_pin_sense u_nmi (
    .clk_i(clk_i),
    .rst_i(in_rst),
    .pin_i(nmi_i),
    .rise_i(nmi_rise),
    .level_i(1'b0),
    .clr_i(nmi_clr),
    .flag_o(nmi_flag)
  );

  // one detector per request pin, each with its own sense bit
  for (genvar g = 0; g < NUM_IRQ; g++) begin : g_irq
    rtie_pin_sense u_irq (
      .clk_i(clk_i),
      .rst_i(in_rst),
      .pin_i(irq_pin_n_i[g]),
      .rise_i(1'b0),
      .level_i(~sense_q[g]),
      .clr_i(flag_wr & ~wr_byte[g]),
      .flag_o(irq_flag[g])
    );
  end

  // priority level per source: pins share bits of the first register,
  // internal sources go three to a bit over the rest
  wire [11:0] pri_int = {pria_q[3:0], prib_q};
  wire [7:0] pri_irq = {pria_q[4], pria_q[4], pria_q[4], pria_q[4], pria_q[5], pria_q[5], pria_q[6], pria_q[7]};
  for (genvar g = 0; g < NUM_INT; g++) begin : g_pri
    assign arb.hi[1 + NUM_IRQ + g] = pri_int[11 - (g / 3)];
  end
  assign arb.hi[NUM_IRQ:1] = pri_irq[NUM_IRQ-1:0];
  assign arb.hi[0] = 1'b1;

  // requests: the nmi flag, enabled pin flags, and peripheral levels
  assign arb.req = {int_req_i, irq_flag & pinen_q[NUM_IRQ-1:0], nmi_flag};
  // three mask levels; without user bit enable the second bit lets only high level through
  assign arb.allow_lo = ~cond_mask;
  assign arb.allow_hi = ~cond_mask | (~user_bit_enable & ~user_or_mask_bit);

  rtie_arbiter #(.N(NSRC)) u_arb (
    .a(arb)
  );

  // entry only from the run state, which is why nothing preempts the first instruction
  wire in_run = state_q == rtie_pkg::ST_RUN;
  wire int_take = in_run & arb.valid;
  // a trap waits behind any accepted interrupt, so it ranks lowest
  wire trap_take = in_run & ~arb.valid & trap_req_i;
  wire take = int_take | trap_take;
  wire [5:0] int_vec = arb.idx == 6'h00 ? `RTIE_VEC_NMI : arb.idx + `RTIE_VEC_SRC_OFS;
  wire [5:0] trap_vec = `RTIE_VEC_TRAP + {4'h0, trap_num_i};
  wire [5:0] take_vec = int_take ? int_vec : trap_vec;
  wire fetch_done = state_q == rtie_pkg::ST_FETCH && vec_ack_i && byte_q == `RTIE_VEC_LAST_BYTE;
  wire [15:0] frame_sp = stack_pointer_i - `RTIE_FRAME_BYTES;

  // sequencer next state
  always_comb begin
    state_d = state_q;
    case (state_q)
      rtie_pkg::ST_RESET: begin
        state_d = rtie_pkg::ST_INIT;
      end
      rtie_pkg::ST_INIT: begin
        state_d = rtie_pkg::ST_FETCH;
      end
      rtie_pkg::ST_FETCH: begin
        if (fetch_done) state_d = boot_q ? rtie_pkg::ST_FIRST : rtie_pkg::ST_RUN;
      end
      rtie_pkg::ST_FIRST: begin
        if (first_done_i) state_d = rtie_pkg::ST_RUN;
      end
      rtie_pkg::ST_RUN: begin
        if (take) state_d = rtie_pkg::ST_PUSH;
      end
      rtie_pkg::ST_PUSH: begin
        if (push_ack_i) state_d = rtie_pkg::ST_FETCH;
      end
      default: begin
        state_d = rtie_pkg::ST_RESET;
      end
    endcase
  end

  // state stays in reset while any reset source is active
  always_ff @(posedge clk_i) begin
    if (in_rst) begin
      state_q <= rtie_pkg::ST_RESET;
      boot_q <= 1'b1;
    end else begin
      state_q <= state_d;
      boot_q <= boot_q & ~(state_q == rtie_pkg::ST_FIRST && first_done_i);
    end
  end

  // vector fetch: four bytes, most significant first
  always_ff @(posedge clk_i) begin
    if (in_rst) begin
      byte_q <= 2'h0;
      vaddr_q <= `RTIE_VADDR_RESET;
      jaddr_q <= 32'h00000000;
    end else if (take) begin
      byte_q <= 2'h0;
      vaddr_q <= {take_vec, 2'b00};
    end else if (state_q == rtie_pkg::ST_FETCH && vec_ack_i) begin
      byte_q <= byte_q + 2'h1;
      vaddr_q <= vaddr_q + 8'h01;
      jaddr_q <= {jaddr_q[23:0], vec_data_i};
    end
  end

  // interrupt entry never touches the user bit; only a trap may set it
  // one-cycle strobes toward the core
  always_ff @(posedge clk_i) begin
    if (in_rst) begin
      jump_q <= 1'b0;
      set_imask_q <= 1'b0;
      set_uimask_q <= 1'b0;
      int_ack_q <= 1'b0;
      trap_ack_q <= 1'b0;
    end else begin
      jump_q <= fetch_done;
      set_imask_q <= state_q == rtie_pkg::ST_INIT || take;
      set_uimask_q <= trap_take & ~user_bit_enable;
      int_ack_q <= int_take;
      trap_ack_q <= trap_take;
    end
  end

  // source vector and even stack frame address captured at entry
  always_ff @(posedge clk_i) begin
    if (in_rst) begin
      int_vec_q <= 6'h00;
      push_addr_q <= 16'h0000;
    end else if (take) begin
      int_vec_q <= take_vec;
      push_addr_q <= {frame_sp[15:1], 1'b0};
    end
  end

  // word and longword accesses never reach an odd byte; costs one cycle of latency
  always_ff @(posedge clk_i) begin
    if (in_rst) begin
      mem_addr_q <= 16'h0000;
    end else begin
      mem_addr_q <= mem_wide_i ? {mem_addr_i[15:1], 1'b0} : mem_addr_i;
    end
  end

  // halt and peripheral reset are combinational so they act in the cycle the pin falls
  // outputs
  assign wb_ack_o = wb_ack_q;
  assign wb_dat_o = wb_dat_q;
  assign cpu_halt_o = in_rst | (state_q == rtie_pkg::ST_RESET);
  assign periph_reset_o = in_rst;
  assign set_imask_o = set_imask_q;
  assign set_uimask_o = set_uimask_q;
  assign vec_rd_o = state_q == rtie_pkg::ST_FETCH;
  assign vec_addr_o = {8'h00, vaddr_q};
  assign jump_o = jump_q;
  assign jump_addr_o = jaddr_q;
  assign push_req_o = state_q == rtie_pkg::ST_PUSH;
  assign push_addr_o = push_addr_q;
  assign int_ack_o = int_ack_q;
  assign int_vector_o = int_vec_q;
  assign trap_ack_o = trap_ack_q;
  assign mem_addr_o = mem_addr_q;
endmodule

// [testbench/rtie_chk.sv]
`timescale 1ns/1ps
module rtie_chk (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic reset_pin_n_i,
  input wire logic wdt_overflow_i,
  input wire logic wb_we_i,
  input wire logic wb_ack_o,
  input wire logic [17:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [15:0] stack_pointer_i,
  input wire logic first_done_i,
  input wire logic [1:0] trap_num_i,
  input wire logic vec_ack_i,
  input wire logic [15:0] mem_addr_i,
  input wire logic mem_wide_i,
  input wire logic cpu_halt_o,
  input wire logic periph_reset_o,
  input wire logic set_imask_o,
  input wire logic set_uimask_o,
  input wire logic vec_rd_o,
  input wire logic [15:0] vec_addr_o,
  input wire logic jump_o,
  input wire logic push_req_o,
  input wire logic [15:0] push_addr_o,
  input wire logic int_ack_o,
  input wire logic [5:0] int_vector_o,
  input wire logic trap_ack_o
);
  logic user_en_q;
  logic first_q;
  // shadow of the user bit enable, so trap masking can be predicted from the bus alone
  always_ff @(posedge clk_i) begin
    if (rst_i || periph_reset_o) begin
      user_en_q <= 1'b1;
      first_q <= 1'b1;
    end else begin
      if (wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i[17:2] == 16'hFFF2) user_en_q <= wb_dat_i[3];
      if (first_done_i) first_q <= 1'b0;
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // reset, entry and fetch relations
  a_pin_halts: assert property (!reset_pin_n_i |-> cpu_halt_o && periph_reset_o)
    else $error("core not halted with reset pin low");
  a_hold_quiet: assert property (!reset_pin_n_i [*2] |-> !vec_rd_o && !jump_o && !int_ack_o)
    else $error("activity while reset pin held low");
  a_release_boot: assert property ($rose(reset_pin_n_i) && !wdt_overflow_i |->
    ##2 set_imask_o && vec_rd_o && vec_addr_o == 16'h0000)
    else $error("reset release did not start vector fetch");
  a_wdt_reboot: assert property (wdt_overflow_i |=> cpu_halt_o ##[2:8] (vec_rd_o && vec_addr_o == 16'h0000))
    else $error("watchdog overflow did not reset and refetch");
  a_vec_step: assert property (vec_rd_o && vec_ack_i && vec_addr_o[1:0] != 2'h3 |=>
    vec_rd_o && vec_addr_o == $past(vec_addr_o) + 16'h0001)
    else $error("vector byte address did not step");
  a_vec_jump: assert property (vec_rd_o && vec_ack_i && vec_addr_o[1:0] == 2'h3 |=> jump_o && !vec_rd_o)
    else $error("no jump after fourth vector byte");
  a_first_free: assert property (first_q |-> !int_ack_o && !trap_ack_o)
    else $error("entry taken before first instruction ended");
  a_trap_mask: assert property (trap_ack_o |-> set_imask_o && set_uimask_o == !user_en_q)
    else $error("trap mask bits wrong");
  a_trap_vector: assert property (trap_ack_o |-> int_vector_o == 6'h08 + {4'h0, $past(trap_num_i)})
    else $error("trap vector wrong");
  a_int_entry: assert property (int_ack_o |-> set_imask_o && !set_uimask_o && push_req_o &&
    push_addr_o == (($past(stack_pointer_i) - 16'h0004) & 16'hFFFE))
    else $error("interrupt entry frame wrong");
  c_trap_user0: cover property (trap_ack_o && !user_en_q);
  c_nmi: cover property (int_ack_o && int_vector_o == 6'h07);
  c_wdt: cover property (wdt_overflow_i);
endmodule

bind rtie_top rtie_chk u_chk (.*);

// [testbench/rtie_mem_model.sv]
`timescale 1ns/1ps
module rtie_mem_model (
  input wire logic clk_i,
  input wire logic slow_i,
  input wire logic vec_rd_i,
  input wire logic [15:0] vec_addr_i,
  input wire logic push_req_i,
  output logic vec_ack_o,
  output logic [7:0] vec_data_o,
  output logic push_ack_o
);
  logic [1:0] wait_q;
  logic busy;
  assign busy = (vec_rd_i || push_req_i) && !vec_ack_o && !push_ack_o;
  initial begin
    vec_ack_o = 1'b0;
    push_ack_o = 1'b0;
    vec_data_o = 8'h3C;
    wait_q = 2'h0;
  end
  // data toggles outside answers, so a late sample never sees the last byte
  always @(posedge clk_i) begin
    vec_ack_o <= 1'b0;
    push_ack_o <= 1'b0;
    vec_data_o <= ~vec_data_o;
    if (busy && wait_q != 2'h0) begin
      wait_q <= wait_q - 2'h1;
    end else if (busy) begin
      vec_ack_o <= vec_rd_i;
      push_ack_o <= push_req_i;
      vec_data_o <= vec_addr_i[7:0] ^ 8'h5A;
      wait_q <= slow_i ? 2'h3 : 2'h0;
    end
  end
endmodule

// [testbench/test_reset_trap_interrupt_entry.sv]
`timescale 1ns/1ps
module test_reset_trap_interrupt_entry;
  logic clk_i, rst_i, reset_pin_n_i, wdt_overflow_i, wb_cyc_i, wb_stb_i, wb_we_i, nmi_i;
  logic first_done_i, trap_req_i, mem_wide_i, slow_i, vec_ack_i, push_ack_i;
  logic wb_ack_o, cpu_halt_o, periph_reset_o, set_imask_o, set_uimask_o, vec_rd_o, jump_o;
  logic push_req_o, int_ack_o, trap_ack_o;
  logic [17:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, jump_addr_o;
  logic [7:0] irq_pin_n_i, cond_code_reg_i, vec_data_i, rd;
  logic [33:0] int_req_i;
  logic [15:0] stack_pointer_i, mem_addr_i, vec_addr_o, push_addr_o, mem_addr_o;
  logic [1:0] trap_num_i;
  logic [5:0] int_vector_o;
  int failures, samples_checked, k1, k2, i;

  rtie_top #(.WDT_HOLD(2)) uut (.*);
  rtie_mem_model u_mem (.clk_i(clk_i), .slow_i(slow_i), .vec_rd_i(vec_rd_o), .vec_addr_i(vec_addr_o),
    .push_req_i(push_req_o), .vec_ack_o(vec_ack_i), .vec_data_o(vec_data_i), .push_ack_o(push_ack_i));

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  task automatic end_of_test;
    $display("Checked %0d samples, %0d failures", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // start address the model memory holds for a vector
  function automatic logic [31:0] jv(input logic [5:0] v);
    logic [7:0] a;
    a = {v, 2'b00};
    return {a ^ 8'h5A, (a + 8'h01) ^ 8'h5A, (a + 8'h02) ^ 8'h5A, (a + 8'h03) ^ 8'h5A};
  endfunction

  // one classic cycle; the master waits for ack however long, a dead slave is left to the watchdog
  task automatic bus(input logic w, input logic [15:0] idx, input logic [7:0] d, output logic [7:0] q);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= {idx, 2'b00};
    wb_dat_i <= {24'h000000, d};
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    chk(wb_ack_o, 1'b1);
    q = wb_dat_o[7:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  task automatic wait_jump(input logic [5:0] v);
    int n;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (jump_o !== 1'b1 && n < 200);
    chk(jump_o, 1'b1);
    chk(jump_addr_o, jv(v));
  endtask

  // the handler masks every source but the nmi once it is entered
  task automatic entry(input logic [5:0] v);
    int n;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (int_ack_o !== 1'b1 && trap_ack_o !== 1'b1 && n < 200);
    chk({int_ack_o, trap_ack_o}, (v >= 6'h08 && v <= 6'h0B) ? 2'h1 : 2'h2);
    chk(int_vector_o, v);
    chk(push_addr_o, (stack_pointer_i - 16'h0004) & 16'hFFFE);
    trap_req_i <= 1'b0;
    cond_code_reg_i <= 8'hC0;
    if (v >= 6'h14) int_req_i <= '0;
    wait_jump(v);
  endtask

  task automatic quiet(input int n);
    repeat (n) begin
      @(posedge clk_i);
      chk(int_ack_o, 1'b0);
    end
  endtask

  task automatic first_instr;
    @(posedge clk_i);
    first_done_i <= 1'b1;
    stack_pointer_i <= 16'($urandom()) | 16'h0001;
    @(posedge clk_i);
    first_done_i <= 1'b0;
  endtask

  initial begin
    #200000;
    failures++;
    end_of_test;
  end

  initial begin
    failures = 0;
    samples_checked = 0;
    i = $urandom(32'h6D9CC930);
    {rst_i, reset_pin_n_i, wdt_overflow_i, wb_cyc_i, wb_stb_i, wb_we_i} = 6'h20;
    {first_done_i, trap_req_i, mem_wide_i, slow_i, nmi_i} = 5'h01;
    {wb_adr_i, wb_sel_i, wb_dat_i, trap_num_i} = {18'h00000, 4'hF, 32'h00000000, 2'h0};
    {irq_pin_n_i, int_req_i, cond_code_reg_i} = {8'hFF, 34'h000000000, 8'h80};
    {stack_pointer_i, mem_addr_i} = {16'h0100, 16'h0000};
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (12) @(posedge clk_i);
    reset_pin_n_i <= 1'b1;
    wait_jump(6'h00);
    // an nmi edge during the first instruction must wait for it
    nmi_i <= 1'b0;
    quiet(6);
    first_instr;
    nmi_i <= 1'b1;
    entry(6'h07);
    // reset values, read-write and an unmapped hole
    bus(1'b0, 16'hFFF2, 8'h00, rd);
    chk(rd, 8'h0B);
    foreach (int_req_i[i]) if (i < 5) begin
      bus(1'b0, 16'hFFF4 + 16'(i), 8'h00, rd);
      chk(rd, 8'h00);
    end
    bus(1'b1, 16'hFFF9, 8'h5A, rd);
    bus(1'b0, 16'hFFF9, 8'h00, rd);
    chk(rd, 8'h5A);
    bus(1'b1, 16'hFFF3, 8'h5A, rd);
    bus(1'b0, 16'hFFF3, 8'h00, rd);
    chk(rd, 8'h00);
    // traps with both user bit options, prompt and slow memory, wide and narrow accesses
    for (i = 0; i < 4; i++) begin
      bus(1'b1, 16'hFFF2, {4'h0, i[0], 3'h3}, rd);
      mem_addr_i <= 16'($urandom());
      mem_wide_i <= i[0];
      slow_i <= i[1];
      @(posedge clk_i);
      @(posedge clk_i);
      chk(mem_addr_o, mem_addr_i & {15'h7FFF, ~mem_wide_i});
      trap_num_i <= i[1:0];
      trap_req_i <= 1'b1;
      entry(6'h08 + 6'(i));
    end
    // two falling edges at once: the high level wins, the low one waits under the mask
    k1 = $urandom() % 4;
    k2 = 4 + $urandom() % 4;
    bus(1'b1, 16'hFFF8, 8'h10, rd);
    bus(1'b1, 16'hFFF4, 8'hFF, rd);
    bus(1'b1, 16'hFFF5, 8'(1 << k1) | 8'(1 << k2), rd);
    bus(1'b1, 16'hFFF2, 8'h03, rd);
    cond_code_reg_i <= 8'h80;
    irq_pin_n_i <= ~(8'(1 << k1) | 8'(1 << k2));
    entry(6'h0C + 6'(k2));
    bus(1'b1, 16'hFFF6, 8'hFF, rd);
    bus(1'b0, 16'hFFF6, 8'h00, rd);
    chk(rd, 8'(1 << k1) | 8'(1 << k2));
    bus(1'b1, 16'hFFF6, ~8'(1 << k2), rd);
    bus(1'b0, 16'hFFF6, 8'h00, rd);
    chk(rd, 8'(1 << k1));
    cond_code_reg_i <= 8'h80;
    quiet(20);
    cond_code_reg_i <= 8'h00;
    entry(6'h0C + 6'(k1));
    // a level-sensed pin still held low sets its flag again over a clear
    bus(1'b1, 16'hFFF4, ~8'(1 << k1), rd);
    bus(1'b1, 16'hFFF6, 8'h00, rd);
    bus(1'b0, 16'hFFF6, 8'h00, rd);
    chk(rd, 8'(1 << k1));
    irq_pin_n_i <= 8'hFF;
    bus(1'b1, 16'hFFF6, 8'h00, rd);
    bus(1'b0, 16'hFFF6, 8'h00, rd);
    chk(rd, 8'h00);
    // rising nmi select ignores a fall, then beats an internal request
    bus(1'b1, 16'hFFF2, 8'h07, rd);
    nmi_i <= 1'b0;
    quiet(8);
    k1 = $urandom() % 34;
    nmi_i <= 1'b1;
    int_req_i[k1] <= 1'b1;
    entry(6'h07);
    cond_code_reg_i <= 8'h00;
    entry(6'h14 + 6'(k1));
    // watchdog overflow with a trap pending
    @(posedge clk_i);
    wdt_overflow_i <= 1'b1;
    trap_req_i <= 1'b1;
    @(posedge clk_i);
    wdt_overflow_i <= 1'b0;
    trap_req_i <= 1'b0;
    wait_jump(6'h00);
    first_instr;
    quiet(10);
    bus(1'b0, 16'hFFF2, 8'h00, rd);
    chk(rd, 8'h0B);
    // pin reset in mid-run
    reset_pin_n_i <= 1'b0;
    repeat (10) begin
      @(posedge clk_i);
      chk(cpu_halt_o, 1'b1);
    end
    reset_pin_n_i <= 1'b1;
    wait_jump(6'h00);
    end_of_test;
  end
endmodule
